// >>> include/mdm_map.svh
// register offsets, field positions, reset values and timing of the mdio master
`ifndef MDM_MAP_SVH
`define MDM_MAP_SVH

// core clock and management clock limit
`define MDM_CLK_HZ 50000000
`define MDM_MDC_MAX_HZ 25000000
`define MDM_PRESC_MIN ((`MDM_CLK_HZ + 2 * `MDM_MDC_MAX_HZ - 1) / (2 * `MDM_MDC_MAX_HZ) - 1)

// register byte offsets
`define MDM_OFF_STATUS 8'h00
`define MDM_OFF_CMD 8'h04
`define MDM_OFF_DATA 8'h08
`define MDM_OFF_CFG 8'h0C
`define MDM_OFF_SCAN_RANGE 8'h10
`define MDM_OFF_SCAN_CMP 8'h14
`define MDM_OFF_LAST_RES 8'h18
`define MDM_OFF_LAST_VLD 8'h1C
`define MDM_OFF_STICKY 8'h20

// status fields
`define MDM_ST_RD_PEND 0
`define MDM_ST_WR_PEND 1
`define MDM_ST_OPR_PEND 2
`define MDM_ST_BUSY 3
`define MDM_ST_SCANNING 4

// command fields
`define MDM_CMD_VALID 31
`define MDM_CMD_SCAN 30
`define MDM_CMD_ONCE 29
`define MDM_CMD_OP_HI 28
`define MDM_CMD_OP_LO 27
`define MDM_CMD_PHY_HI 26
`define MDM_CMD_PHY_LO 22
`define MDM_CMD_REG_HI 21
`define MDM_CMD_REG_LO 17
`define MDM_CMD_WD_HI 15

// data, config and scan fields
`define MDM_DATA_OK 16
`define MDM_CFG_ST_HI 9
`define MDM_CFG_ST_LO 8
`define MDM_RANGE_HI_HI 12
`define MDM_RANGE_HI_LO 8
`define MDM_CMP_EXP_LO 16

// reset values
`define MDM_PRESC_RST 8'h09
`define MDM_ST_CLAUSE22 2'h1
`define MDM_ST_CLAUSE45 2'h0

// frame layout
`define MDM_PREAMBLE 32'hFFFF_FFFF
`define MDM_TA_WRITE 2'h2
`define MDM_TA_BIT 7'd46
`define MDM_TA_CHECK 7'd47
`define MDM_DATA_BIT 7'd48
`define MDM_FRAME_BITS 7'd64

`endif

// >>> include/mdm_pkg.sv
// types shared by the mdio master
`default_nettype none
package mdm_pkg;
   typedef enum logic [0:0] {
      MDM_IDLE  = 1'b0,
      MDM_SHIFT = 1'b1
   } mdm_frame_e;

   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] regad;
      logic [15:0] wdata;
   } mdm_cmd_s;
endpackage : mdm_pkg
`default_nettype wire

// >>> rtl/mdm_master.sv
// mdio management master with command queue and phy scan
// Behaviour
// - frames use clause 22 or clause 45 start and operation encodings
// - data out changes and data in is sampled only at mdc falling edge
// - data pin released between frames and during read turnaround and data
// - mdc is core clock divided by 2 * (prescale + 1), never above 25 MHz
// - writing command valid queues the command; valid reads back as zero
// - status shows separate pending read and pending write flags
// - completed single read places returned value in read value field
// - data register carries read success beside read value
// - small queue accepts commands while operation pending is clear, runs in order
// - each completed single read overwrites the single read value field; scan reads leave it alone
// - reset selects clause 22; software programs clause 45 encodings
// - scan repeatedly reads a register and flags differences sticky and by interrupt
// - scan walks phy addresses from low to high bound at command register address
// - scan starts when scan bit written with a read operation
// - scan once stops after one pass, otherwise scan loops
// - while scanning only scan, once, operation and register fields are taken
// - mismatch when read differs from expected at a mask one bit
// - last result holds one bit per phy, zero means mismatch
// - last valid shows per phy whether the scan read succeeded
// - sticky register accumulates mismatches, read returns value then sets all ones
// - interrupt high while any sticky mismatch recorded, cleared by sticky read
`default_nettype none
`include "mdm_map.svh"
module mdm_master #(
   parameter int QDEPTH = 2
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // management link
   output logic mdc_o,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   // scan interrupt
   output logic irq_o
);
   localparam int QAW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic wb_req;
   logic wb_wr;
   logic wb_rd;
   logic [7:0] wb_off;
   logic [31:0] rd_mux;
   logic cmd_wr;
   logic sticky_rd;

   assign wb_req = cyc_i & stb_i & ~ack_o;
   // partial-word writes are ignored
   assign wb_wr = wb_req & we_i & (sel_i == 4'hF);
   assign wb_rd = wb_req & ~we_i;
   assign wb_off = {adr_i[7:2], 2'b00};
   assign cmd_wr = wb_wr && (wb_off == `MDM_OFF_CMD);
   assign sticky_rd = wb_rd && (wb_off == `MDM_OFF_STICKY);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (wb_rd) begin
         dat_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration and command fields
   logic [7:0] presc_reg;
   logic [1:0] st_reg;
   logic [4:0] scan_lo_reg;
   logic [4:0] scan_hi_reg;
   logic [15:0] exp_reg;
   logic [15:0] mask_reg;
   logic scan_en_reg;
   logic scan_once_reg;
   logic [1:0] op_reg;
   logic [4:0] phy_reg;
   logic [4:0] regad_reg;
   logic [15:0] wdata_reg;
   logic scan_active_reg;
   logic [4:0] scan_phy_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_reg <= `MDM_PRESC_RST;
         st_reg <= `MDM_ST_CLAUSE22;
         scan_lo_reg <= 5'h00;
         scan_hi_reg <= 5'h00;
         exp_reg <= 16'h0000;
         mask_reg <= 16'h0000;
      end else if (wb_wr) begin
         if (wb_off == `MDM_OFF_CFG) begin
            presc_reg <= dat_i[7:0];
            st_reg <= dat_i[`MDM_CFG_ST_HI:`MDM_CFG_ST_LO];
         end else if (wb_off == `MDM_OFF_SCAN_RANGE) begin
            scan_lo_reg <= dat_i[4:0];
            scan_hi_reg <= dat_i[`MDM_RANGE_HI_HI:`MDM_RANGE_HI_LO];
         end else if (wb_off == `MDM_OFF_SCAN_CMP) begin
            mask_reg <= dat_i[15:0];
            exp_reg <= dat_i[31:`MDM_CMP_EXP_LO];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_en_reg <= 1'b0;
         scan_once_reg <= 1'b0;
         op_reg <= 2'h0;
         phy_reg <= 5'h00;
         regad_reg <= 5'h00;
         wdata_reg <= 16'h0000;
      end else if (cmd_wr) begin
         scan_en_reg <= dat_i[`MDM_CMD_SCAN];
         scan_once_reg <= dat_i[`MDM_CMD_ONCE];
         op_reg <= dat_i[`MDM_CMD_OP_HI:`MDM_CMD_OP_LO];
         regad_reg <= dat_i[`MDM_CMD_REG_HI:`MDM_CMD_REG_LO];
         if (!scan_active_reg) begin
            phy_reg <= dat_i[`MDM_CMD_PHY_HI:`MDM_CMD_PHY_LO];
            wdata_reg <= dat_i[`MDM_CMD_WD_HI:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command queue
   mdm_pkg::mdm_cmd_s q_mem [QDEPTH];
   logic [QAW-1:0] q_wr_ptr;
   logic [QAW-1:0] q_rd_ptr;
   logic [QAW:0] q_cnt;
   logic q_full;
   logic q_push;
   logic q_pop;
   logic [QDEPTH-1:0] q_has_rd;
   logic [QDEPTH-1:0] q_has_wr;

   assign q_full = (q_cnt == (QAW+1)'(QDEPTH));
   // a command offered while the queue is full is dropped
   assign q_push = cmd_wr & dat_i[`MDM_CMD_VALID] & ~dat_i[`MDM_CMD_SCAN] & ~q_full;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_wr_ptr <= '0;
         q_rd_ptr <= '0;
         q_cnt <= '0;
      end else begin
         if (q_push) begin
            q_wr_ptr <= QAW'((q_wr_ptr + 1'b1) % QDEPTH);
         end
         if (q_pop) begin
            q_rd_ptr <= QAW'((q_rd_ptr + 1'b1) % QDEPTH);
         end
         q_cnt <= q_cnt + (QAW+1)'(q_push) - (QAW+1)'(q_pop);
      end
   end

   always_ff @(posedge clk_i) begin
      if (q_push) begin
         q_mem[q_wr_ptr] <= '{op: dat_i[`MDM_CMD_OP_HI:`MDM_CMD_OP_LO],
                              phy: dat_i[`MDM_CMD_PHY_HI:`MDM_CMD_PHY_LO],
                              regad: dat_i[`MDM_CMD_REG_HI:`MDM_CMD_REG_LO],
                              wdata: dat_i[`MDM_CMD_WD_HI:0]};
      end
   end

   for (genvar g = 0; g < QDEPTH; g++) begin : g_entry
      logic occ;
      assign occ = (QAW+1)'((QAW'(g) - q_rd_ptr) % QDEPTH) < q_cnt;
      assign q_has_rd[g] = occ & q_mem[g].op[1];
      assign q_has_wr[g] = occ & ~q_mem[g].op[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // mdc divider and input synchroniser
   logic [7:0] presc_eff;
   logic [7:0] div_cnt;
   logic mdc_reg;
   logic tick;
   logic fall;
   logic mdio_s1;
   logic mdio_s2;
   logic mdio_s3;
   logic mdio_f;

   // a too small prescale is raised so mdc stays within its limit
   assign presc_eff = (presc_reg < 8'(`MDM_PRESC_MIN)) ? 8'(`MDM_PRESC_MIN) : presc_reg;
   assign tick = (div_cnt >= presc_eff);
   assign fall = tick & mdc_reg;
   assign mdc_o = mdc_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= 8'h00;
         mdc_reg <= 1'b0;
      end else begin
         div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
         mdc_reg <= tick ? ~mdc_reg : mdc_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
         mdio_s3 <= 1'b1;
         mdio_f <= 1'b1;
      end else begin
         mdio_s1 <= mdio_i;
         mdio_s2 <= mdio_s1;
         mdio_s3 <= mdio_s2;
         if (mdio_s2 == mdio_s3) begin
            mdio_f <= mdio_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame engine
   mdm_pkg::mdm_frame_e state_reg;
   mdm_pkg::mdm_cmd_s nxt_cmd;
   logic start;
   logic [63:0] frame_vec;
   logic [63:0] shift_reg;
   logic [6:0] bit_cnt;
   logic cur_rd;
   logic cur_scan;
   logic [4:0] cur_phy;
   logic [15:0] rx_reg;
   logic ta_err;
   logic done_reg;

   // queued single commands go ahead of the scan
   assign start = fall && (state_reg == mdm_pkg::MDM_IDLE) && ((q_cnt != '0) || scan_active_reg);
   assign q_pop = start && (q_cnt != '0);
   always_comb begin
      if (q_cnt != '0) begin
         nxt_cmd = q_mem[q_rd_ptr];
      end else begin
         nxt_cmd = '{op: op_reg, phy: scan_phy_reg, regad: regad_reg, wdata: 16'h0000};
      end
   end
   assign frame_vec = {`MDM_PREAMBLE, st_reg, nxt_cmd.op, nxt_cmd.phy, nxt_cmd.regad,
                       `MDM_TA_WRITE, nxt_cmd.wdata};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= mdm_pkg::MDM_IDLE;
         shift_reg <= 64'h0;
         bit_cnt <= 7'd0;
         cur_rd <= 1'b0;
         cur_scan <= 1'b0;
         cur_phy <= 5'h00;
         rx_reg <= 16'h0000;
         ta_err <= 1'b0;
         mdio_o <= 1'b1;
         mdio_oe_o <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            mdm_pkg::MDM_IDLE: begin
               if (start) begin
                  shift_reg <= {frame_vec[62:0], 1'b0};
                  mdio_o <= frame_vec[63];
                  mdio_oe_o <= 1'b1;
                  bit_cnt <= 7'd1;
                  cur_rd <= nxt_cmd.op[1];
                  cur_scan <= (q_cnt == '0);
                  cur_phy <= nxt_cmd.phy;
                  ta_err <= 1'b0;
                  state_reg <= mdm_pkg::MDM_SHIFT;
               end
            end
            mdm_pkg::MDM_SHIFT: begin
               if (fall) begin
                  if (cur_rd && (bit_cnt - 7'd1 == `MDM_TA_CHECK)) begin
                     ta_err <= mdio_f;
                  end
                  if (cur_rd && (bit_cnt - 7'd1 >= `MDM_DATA_BIT)) begin
                     rx_reg <= {rx_reg[14:0], mdio_f};
                  end
                  if (bit_cnt == `MDM_FRAME_BITS) begin
                     mdio_oe_o <= 1'b0;
                     mdio_o <= 1'b1;
                     done_reg <= 1'b1;
                     state_reg <= mdm_pkg::MDM_IDLE;
                  end else begin
                     mdio_o <= shift_reg[63];
                     shift_reg <= {shift_reg[62:0], 1'b0};
                     mdio_oe_o <= ~(cur_rd && (bit_cnt >= `MDM_TA_BIT));
                     bit_cnt <= bit_cnt + 7'd1;
                  end
               end
            end
            default: begin
               state_reg <= mdm_pkg::MDM_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // results of single reads
   logic [15:0] read_value_reg;
   logic read_ok_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_value_reg <= 16'h0000;
         read_ok_reg <= 1'b0;
      end else if (done_reg && cur_rd && !cur_scan) begin
         read_value_reg <= rx_reg;
         read_ok_reg <= ~ta_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scan sequencing and results
   logic scan_rec;
   logic scan_mm;
   logic [31:0] scan_last_result_reg;
   logic [31:0] scan_last_valid_reg;
   logic [31:0] scan_sticky_mismatch_reg;

   assign scan_rec = done_reg & cur_scan;
   // a failed read is never counted as a mismatch
   assign scan_mm = (|((rx_reg ^ exp_reg) & mask_reg)) & ~ta_err;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_active_reg <= 1'b0;
         scan_phy_reg <= 5'h00;
      end else begin
         if (scan_rec && scan_active_reg) begin
            if (cur_phy == scan_hi_reg) begin
               scan_phy_reg <= scan_lo_reg;
               if (scan_once_reg) begin
                  scan_active_reg <= 1'b0;
               end
            end else begin
               scan_phy_reg <= cur_phy + 5'h01;
            end
         end
         if (cmd_wr) begin
            if (!(dat_i[`MDM_CMD_SCAN] && dat_i[`MDM_CMD_OP_HI])) begin
               scan_active_reg <= 1'b0;
            end else if (!scan_active_reg) begin
               scan_active_reg <= 1'b1;
               scan_phy_reg <= scan_lo_reg;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_last_result_reg <= 32'hFFFF_FFFF;
         scan_last_valid_reg <= 32'h0000_0000;
         scan_sticky_mismatch_reg <= 32'hFFFF_FFFF;
      end else begin
         if (sticky_rd) begin
            scan_sticky_mismatch_reg <= 32'hFFFF_FFFF;
         end
         if (scan_rec) begin
            scan_last_result_reg[cur_phy] <= ~scan_mm;
            scan_last_valid_reg[cur_phy] <= ~ta_err;
            if (scan_mm) begin
               scan_sticky_mismatch_reg[cur_phy] <= 1'b0;
            end
         end
      end
   end

   assign irq_o = ~&scan_sticky_mismatch_reg;

   ////////////////////////////////////////////////////////////////////////////
   // status and read mux
   logic rd_pend;
   logic wr_pend;
   logic busy;
   logic cur_busy;

   assign cur_busy = (state_reg == mdm_pkg::MDM_SHIFT) | done_reg;
   assign rd_pend = (|q_has_rd) | (cur_busy & cur_rd & ~cur_scan);
   assign wr_pend = (|q_has_wr) | (cur_busy & ~cur_rd & ~cur_scan);
   assign busy = (q_cnt != '0) | cur_busy | scan_active_reg;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wb_off == `MDM_OFF_STATUS) begin
         rd_mux[`MDM_ST_RD_PEND] = rd_pend;
         rd_mux[`MDM_ST_WR_PEND] = wr_pend;
         rd_mux[`MDM_ST_OPR_PEND] = q_full;
         rd_mux[`MDM_ST_BUSY] = busy;
         rd_mux[`MDM_ST_SCANNING] = scan_active_reg;
      end else if (wb_off == `MDM_OFF_CMD) begin
         rd_mux = {1'b0, scan_en_reg, scan_once_reg, op_reg, phy_reg, regad_reg, 1'b0,
                   wdata_reg};
      end else if (wb_off == `MDM_OFF_DATA) begin
         rd_mux[`MDM_DATA_OK:0] = {read_ok_reg, read_value_reg};
      end else if (wb_off == `MDM_OFF_CFG) begin
         rd_mux[`MDM_CFG_ST_HI:0] = {st_reg, presc_reg};
      end else if (wb_off == `MDM_OFF_SCAN_RANGE) begin
         rd_mux[`MDM_RANGE_HI_HI:0] = {scan_hi_reg, 3'h0, scan_lo_reg};
      end else if (wb_off == `MDM_OFF_SCAN_CMP) begin
         rd_mux = {exp_reg, mask_reg};
      end else if (wb_off == `MDM_OFF_LAST_RES) begin
         rd_mux = scan_last_result_reg;
      end else if (wb_off == `MDM_OFF_LAST_VLD) begin
         rd_mux = scan_last_valid_reg;
      end else if (wb_off == `MDM_OFF_STICKY) begin
         rd_mux = scan_sticky_mismatch_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pin_idle_release: assert property (
      (state_reg == mdm_pkg::MDM_IDLE) && !$past(start) |-> !mdio_oe_o)
      else $error("mdio driven outside a frame");
   a_read_turn_free: assert property (
      (state_reg == mdm_pkg::MDM_SHIFT) && cur_rd && (bit_cnt > `MDM_TA_BIT) |-> !mdio_oe_o)
      else $error("mdio driven while phy returns data");
   a_data_on_fall: assert property ($changed(mdio_o) |-> $fell(mdc_o))
      else $error("mdio changed away from an mdc falling edge");
   a_mdc_divider: assert property ($changed(mdc_o) |-> $past(div_cnt) >= $past(presc_eff))
      else $error("mdc toggled off the prescale count");
   a_queue_count: assert property (
      q_push && !q_pop |=> q_cnt == $past(q_cnt) + (QAW+1)'(1))
      else $error("accepted command not queued");
   a_busy_track: assert property ((q_cnt != '0) || cur_busy |-> busy)
      else $error("busy clear with work outstanding");
   a_read_stores: assert property (
      done_reg && cur_rd && !cur_scan |=> read_value_reg == $past(rx_reg)
      && read_ok_reg == !$past(ta_err))
      else $error("read result not stored");
   a_sticky_reset: assert property (sticky_rd && !scan_rec |=> !irq_o && ack_o)
      else $error("sticky read did not clear");
   a_mask_match: assert property (
      scan_rec && !scan_mm |=> scan_last_result_reg[$past(cur_phy)])
      else $error("masked match recorded as mismatch");
   a_scan_bound: assert property (
      scan_rec && scan_active_reg && (cur_phy == scan_hi_reg) && !cmd_wr
      |=> scan_phy_reg == $past(scan_lo_reg))
      else $error("scan did not wrap to low bound");

   c_single_write: cover property (done_reg && !cur_rd && !cur_scan);
   c_single_read: cover property (done_reg && cur_rd && !cur_scan && !ta_err);
   c_scan_mismatch: cover property (scan_rec && scan_mm);
   c_sticky_read: cover property (sticky_rd && irq_o);
endmodule : mdm_master
`default_nettype wire

// >>> verif/mdm_phy_model.sv
// behavioural phy answering management frames on a pulled-up data line
`default_nettype none
module mdm_phy_model (
   // link side
   input wire logic mdc_i,
   input wire logic mdio_oe_i,
   input wire logic mdio_m_i,
   output logic mdio_w_o,
   // bench side
   input wire logic [15:0] base_i,
   input wire logic [4:0] absent_i,
   output logic [13:0] hdr_o,
   output logic [15:0] wdat_o,
   output int frames_o,
   output int oe_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act = 1'b0;
   logic drv = 1'b0;
   logic dbit = 1'b1;
   logic [13:0] sr = 14'h0;
   logic [15:0] rd = 16'h0;
   int idx = 63;
   initial begin
      frames_o = 0;
      oe_err_o = 0;
      hdr_o = 14'h0;
      wdat_o = 16'h0;
   end
   ////////////////////////////////////////////////////////////////
   // released line sits at the pull-up level, never at the last bit
   assign mdio_w_o = mdio_oe_i ? mdio_m_i : (drv ? dbit : 1'b1);
   // phy works at mdc rise, half a bit away from the master's fall
   always @(posedge mdc_i) begin
      drv = 1'b0;
      if (act) idx = idx + 1;
      else if (mdio_oe_i) begin
         act = 1'b1;
         idx = 0;
      end
      if (act && idx < 46) sr = {sr[12:0], mdio_w_o};
      if (act && idx == 45) begin
         hdr_o = sr;
         rd = base_i ^ {11'h0, sr[9:5]};
      end
      if (act && idx >= 46 && hdr_o[11]) begin
         if (mdio_oe_i) oe_err_o++;
         drv = idx > 46 && hdr_o[9:5] != absent_i;
         dbit = idx == 47 ? 1'b0 : rd[4'(63 - idx)];
      end
      if (act && idx >= 48 && !hdr_o[11]) wdat_o = {wdat_o[14:0], mdio_w_o};
      if (act && idx == 63) begin
         act = 1'b0;
         frames_o++;
      end
   end
endmodule : mdm_phy_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the mdio master with phy scan
`default_nettype none
`include "mdm_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o, mdc_o, mdio_o, mdio_oe_o, irq_o, mdio_w;
   logic [15:0] base = 16'h0;
   logic [4:0] absent = 5'h1F;
   logic [13:0] hdr;
   logic [15:0] wdat;
   logic [31:0] seed = 32'h62CF2077;
   logic [31:0] q, e1, e2;
   logic pm = 1'b0;
   logic [1:0] pd = 2'b10;
   int frames, oe_err;
   int n_errors = 0;
   int total_checks = 0;
   int edge_err = 0;
   always #10 clk_i = ~clk_i;
   mdm_master uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .mdc_o(mdc_o), .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));
   mdm_phy_model phy (.mdc_i(mdc_o), .mdio_oe_i(mdio_oe_o), .mdio_m_i(mdio_o),
      .mdio_w_o(mdio_w), .base_i(base), .absent_i(absent), .hdr_o(hdr), .wdat_o(wdat),
      .frames_o(frames), .oe_err_o(oe_err));
   // pin and enable may move only where mdc has just fallen
   always @(negedge clk_i) begin
      if (!rst_i && {mdio_o, mdio_oe_o} !== pd && !(pm && !mdc_o)) edge_err++;
      pm = mdc_o;
      pd = {mdio_o, mdio_oe_o};
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [31:0] cmd(input logic [2:0] f, input logic [1:0] op,
      input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
      return {f, op, p, r, 1'b0, d};
   endfunction : cmd
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] o);
      int i;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      o = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (i == 50) begin
         n_errors++;
         $display("[FAIL] ack expected 1 seen 0");
         complete_run();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] o;
      wb(1'b1, a, d, o);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] o;
      wb(1'b0, a, 32'h0, o);
      chk(nm, e, o);
   endtask : rdc
   // polls busy; a stuck controller ends the run
   task automatic idle;
      logic [31:0] o;
      int i;
      for (i = 0; i < 4000; i++) begin
         wb(1'b0, `MDM_OFF_STATUS, 32'h0, o);
         if (o[`MDM_ST_BUSY] === 1'b0) return;
      end
      n_errors++;
      $display("[FAIL] busy expected 0 seen 1");
      complete_run();
   endtask : idle
   ////////////////////////////////////////////////////////////////
   initial begin
      int i, n, s, p;
      logic pk;
      logic [1:0] op;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("oe idle", 32'h0, mdio_oe_o);
      rdc(`MDM_OFF_CFG, 32'h109, "cfg");
      rdc(`MDM_OFF_LAST_RES, '1, "last result");
      rdc(`MDM_OFF_LAST_VLD, 32'h0, "last valid");
      rdc(`MDM_OFF_STICKY, '1, "sticky");
      rdc(`MDM_OFF_STATUS, 32'h0, "status");
      rdc(8'h3C, 32'h0, "unmapped");
      $display("reset values done");
      for (p = 2; p >= 0; p--) begin
         wr(`MDM_OFF_CFG, 32'h100 | p);
         repeat (30) @(negedge clk_i);
         pk = mdc_o;
         n = 0;
         for (i = 0; i < 60; i++) begin
            @(negedge clk_i);
            if (mdc_o && !pk) n++;
            pk = mdc_o;
         end
         chk("mdc rises", 60 / (2 * p + 2), n);
      end
      $display("clock divider done");
      // both start fields with every operation code
      for (s = 0; s < 8; s++) begin
         seed = lfsr(seed);
         base = seed[31:16];
         op = s[1:0];
         // reads need a slow mdc: the input filter lags the pin by about four clocks
         wr(`MDM_OFF_CFG, {22'h0, 2'(1 - s / 4), 8'h09});
         wr(`MDM_OFF_CMD, cmd(3'b100, op, {1'b0, seed[3:0]}, seed[9:5], seed[31:16]));
         wb(1'b0, `MDM_OFF_STATUS, 32'h0, q);
         chk("pending", {30'h0, !op[1], op[1]}, q & 32'h3);
         idle();
         chk("header", {2'(1 - s / 4), op, 1'b0, seed[3:0], seed[9:5]}, hdr);
         if (op[1]) rdc(`MDM_OFF_DATA, {15'h0, 1'b1, base ^ {12'h0, seed[3:0]}}, "read");
         else chk("write data", seed[31:16], wdat);
      end
      $display("single commands done");
      n = frames;
      wr(`MDM_OFF_CMD, cmd(3'b100, 2'b01, 5'h03, 5'h04, 16'hA5A5));
      wr(`MDM_OFF_CMD, cmd(3'b100, 2'b01, 5'h05, 5'h06, 16'h5A5A));
      wb(1'b0, `MDM_OFF_CMD, 32'h0, q);
      chk("valid self clear", 32'h0, q[`MDM_CMD_VALID]);
      idle();
      chk("frames", n + 2, frames);
      chk("last write", {5'h05, 16'h5A5A}, {hdr[9:5], wdat});
      absent = 5'h07;
      wr(`MDM_OFF_CMD, cmd(3'b100, 2'b10, 5'h07, 5'h01, 16'h0));
      idle();
      wb(1'b0, `MDM_OFF_DATA, 32'h0, q);
      chk("read success", 32'h0, q[`MDM_DATA_OK]);
      $display("queue and read error done");
      // one pass over phys 6 to 9, phy 8 silent, low bits masked off
      seed = lfsr(seed);
      base = seed[31:16];
      absent = 5'h08;
      wr(`MDM_OFF_SCAN_RANGE, 32'h0906);
      wr(`MDM_OFF_SCAN_CMP, {seed[31:16], 16'hFFF8});
      wr(`MDM_OFF_CMD, cmd(3'b011, 2'b10, 5'h1F, 5'h02, 16'hFFFF));
      idle();
      e1 = '1;
      e2 = '0;
      for (p = 6; p < 10; p++) begin
         e2[p] = p != 8;
         e1[p] = !(e2[p] && (p & 16'hFFF8) != 0);
      end
      rdc(`MDM_OFF_LAST_RES, e1, "scan result");
      rdc(`MDM_OFF_LAST_VLD, e2, "scan valid");
      chk("scan header", {2'b00, 2'b10, 5'h09, 5'h02}, hdr);
      chk("irq", 32'h1, irq_o);
      rdc(`MDM_OFF_STICKY, e1, "sticky");
      rdc(`MDM_OFF_STICKY, '1, "sticky cleared");
      chk("irq cleared", 32'h0, irq_o);
      // endless scan outlives one pass until the scan bit is dropped
      wr(`MDM_OFF_CMD, cmd(3'b010, 2'b10, 5'h00, 5'h02, 16'h0));
      repeat (6000) @(posedge clk_i);
      wb(1'b0, `MDM_OFF_STATUS, 32'h0, q);
      chk("still scanning", 32'h1, q[`MDM_ST_SCANNING]);
      wr(`MDM_OFF_CMD, cmd(3'b000, 2'b10, 5'h00, 5'h02, 16'h0));
      idle();
      $display("scan done");
      chk("pin edges", 32'h0, edge_err);
      chk("oe in read", 32'h0, oe_err);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
